// >>> inc/fbm_pkg.sv
package fbm_pkg;
  // clock and bus timing, all in ns unless named _CYC
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CE_NS = 100;
  localparam int T_WP_NS = 50;
  localparam int T_WH_NS = 50;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_REC_NS = 50;
  localparam int T_READY_NE_NS = 500;
  // least times round up to whole cycles
  localparam int CE_CYC = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_NE_CYC = (T_READY_NE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_HV_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RB_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_ABORT_BIT = 3;
  // flash geometry and command cycles
  localparam int ADDR_W = 22;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = 6;
  localparam logic [21:0] PROT_SEL_ADDR = 22'h000002;
  localparam logic [21:0] UNLOCK1_ADDR = 22'h000555;
  localparam logic [21:0] UNLOCK2_ADDR = 22'h0002AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] AUTOSEL_DATA = 8'h90;
  localparam logic [7:0] EXIT_DATA = 8'hF0;
  localparam logic [1:0] AUTOSEL_LAST = 2'h2;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_AUTOSEL = 3'h3,
    OP_PROTQ = 3'h4,
    OP_EXIT = 3'h5
  } fbm_op_e;

  typedef struct packed {
    logic [21:0] addr;
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic reset_n;
    logic [7:0] data_out;
    logic data_oe;
    logic id_hv_en;
  } fbm_pins_s;

  typedef struct packed {
    logic go;
    fbm_op_e op;
    logic [21:0] addr;
    logic [7:0] wdata;
    logic hv;
  } fbm_cmd_s;

  typedef struct packed {
    logic busy;
    logic [7:0] rdata;
    logic done;
    logic aborted;
  } fbm_stat_s;
endpackage : fbm_pkg

// >>> logic/fbm_wait_timer.sv
`timescale 1ns/100ps
module fbm_wait_timer #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } fbm_tmr_s;

  fbm_tmr_s r, n;

  // load_val cycles after a load, expired goes high and stays high
  always_comb
  begin
    n = r;
    if (load)
      n.cnt = load_val - W'(1);
    else if (r.cnt != '0)
      n.cnt = r.cnt - W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign expired = (r.cnt == '0);
endmodule : fbm_wait_timer

// >>> logic/fbm_apb_regs.sv
`timescale 1ns/100ps
module fbm_apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ready_busy_n,
  input fbm_pkg::fbm_stat_s stat,
  output fbm_pkg::fbm_cmd_s cmd
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fbm_pkg::fbm_cmd_s cmd;
    logic [7:0] rdata;
    logic done_st;
    logic abort_st;
    logic rb_q;
  } fbm_regs_s;

  fbm_regs_s r, n;
  logic setup;
  logic wr_acc;
  logic mapped;

  always_comb
  begin
    setup = psel && !penable;
    wr_acc = psel && penable && r.pready && pwrite;
    mapped = (paddr == fbm_pkg::REG_CTRL) || (paddr == fbm_pkg::REG_ADDR) ||
             (paddr == fbm_pkg::REG_WDATA) || (paddr == fbm_pkg::REG_RDATA) ||
             (paddr == fbm_pkg::REG_STAT);
    n = r;
    n.cmd.go = 1'b0;
    n.rb_q = ready_busy_n;
    // answer in the first access cycle, read data taken at setup
    n.pready = setup;
    if (setup)
    begin
      n.pslverr = !mapped;
      n.prdata = '0;
      case (paddr)
        fbm_pkg::REG_CTRL:
        begin
          n.prdata[fbm_pkg::CTRL_OP_LSB +: 3] = r.cmd.op;
          n.prdata[fbm_pkg::CTRL_HV_BIT] = r.cmd.hv;
        end
        fbm_pkg::REG_ADDR: n.prdata[21:0] = r.cmd.addr;
        fbm_pkg::REG_WDATA: n.prdata[7:0] = r.cmd.wdata;
        fbm_pkg::REG_RDATA: n.prdata[7:0] = r.rdata;
        fbm_pkg::REG_STAT:
        begin
          n.prdata[fbm_pkg::STAT_BUSY_BIT] = stat.busy;
          n.prdata[fbm_pkg::STAT_RB_BIT] = r.rb_q;
          n.prdata[fbm_pkg::STAT_DONE_BIT] = r.done_st;
          n.prdata[fbm_pkg::STAT_ABORT_BIT] = r.abort_st;
        end
        default: n.prdata = '0;
      endcase
    end
    // a write lands only at the edge that sees pready
    if (wr_acc)
    begin
      case (paddr)
        fbm_pkg::REG_CTRL:
        begin
          n.cmd.op = fbm_pkg::fbm_op_e'(pwdata[fbm_pkg::CTRL_OP_LSB +: 3]);
          n.cmd.hv = pwdata[fbm_pkg::CTRL_HV_BIT];
          // start ignored while a sequence runs
          n.cmd.go = pwdata[fbm_pkg::CTRL_GO_BIT] && !stat.busy;
        end
        fbm_pkg::REG_ADDR: n.cmd.addr = pwdata[21:0];
        fbm_pkg::REG_WDATA: n.cmd.wdata = pwdata[7:0];
        fbm_pkg::REG_STAT:
        begin
          if (pwdata[fbm_pkg::STAT_DONE_BIT])
            n.done_st = 1'b0;
          if (pwdata[fbm_pkg::STAT_ABORT_BIT])
            n.abort_st = 1'b0;
        end
        default: n.prdata = r.prdata;
      endcase
    end
    // sticky flags: a set in the clearing cycle wins
    if (stat.done)
    begin
      n.done_st = 1'b1;
      n.rdata = stat.rdata;
    end
    if (stat.aborted)
      n.abort_st = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.rb_q <= 1'b1;
    end
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign cmd = r.cmd;
endmodule : fbm_apb_regs

// >>> logic/fbm_ctrl.sv
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module fbm_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_in,
  input wire logic ready_busy_n,
  output fbm_pkg::fbm_pins_s flash_o
);
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RD = 8'h02,
    S_WR_SET = 8'h04,
    S_WR_LO = 8'h08,
    S_WR_HI = 8'h10,
    S_RST_LO = 8'h20,
    S_RST_WAIT = 8'h40,
    S_RST_REC = 8'h80
  } fbm_state_e;

  typedef struct packed {
    fbm_state_e state;
    fbm_pkg::fbm_op_e op;
    logic [1:0] step;
    logic [1:0] last;
    logic abort_pend;
    fbm_pkg::fbm_pins_s pins;
    fbm_pkg::fbm_stat_s stat;
  } fbm_ctrl_s;

  fbm_ctrl_s r, n;
  fbm_pkg::fbm_cmd_s cmd;
  logic tmr_load;
  logic [fbm_pkg::TMR_W-1:0] tmr_val;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////////
  // register file and wait timer
  fbm_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ready_busy_n(ready_busy_n),
    .stat(r.stat),
    .cmd(cmd)
  );

  fbm_wait_timer #(
    .W(fbm_pkg::TMR_W)
  ) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address and data of each command write cycle
  function automatic logic [29:0] fbm_cyc(input fbm_pkg::fbm_op_e op,
                                          input logic [1:0] step,
                                          input logic [21:0] addr,
                                          input logic [7:0] wdata);
    logic [29:0] v;
    v = {addr, wdata};
    if (op == fbm_pkg::OP_AUTOSEL)
    begin
      case (step)
        2'h0: v = {fbm_pkg::UNLOCK1_ADDR, fbm_pkg::UNLOCK1_DATA};
        2'h1: v = {fbm_pkg::UNLOCK2_ADDR, fbm_pkg::UNLOCK2_DATA};
        default: v = {fbm_pkg::UNLOCK1_ADDR, fbm_pkg::AUTOSEL_DATA};
      endcase
    end
    // reset command back to array read
    else if (op == fbm_pkg::OP_EXIT)
      v = {addr, fbm_pkg::EXIT_DATA};
    return v;
  endfunction : fbm_cyc

  ////////////////////////////////////////////////////////////////////////////////
  // bus sequencer
  always_comb
  begin
    n = r;
    tmr_load = 1'b0;
    tmr_val = '0;
    n.stat.done = 1'b0;
    n.stat.aborted = 1'b0;
    // high voltage on A9 follows the control bit
    n.pins.id_hv_en = cmd.hv;
    case (r.state)
      S_IDLE:
      begin
        // deselected and not driving between cycles
        n.pins.chip_select_n = 1'b1;
        n.pins.output_enable_n = 1'b1;
        n.pins.write_strobe_n = 1'b1;
        n.pins.data_oe = 1'b0;
        if (cmd.go)
        begin
          n.stat.busy = 1'b1;
          n.op = cmd.op;
          n.step = 2'h0;
          case (cmd.op)
            fbm_pkg::OP_READ, fbm_pkg::OP_PROTQ:
            begin
              n.pins.addr = cmd.addr;
              // sector on top bits, A1 high selects protection
              if (cmd.op == fbm_pkg::OP_PROTQ)
                n.pins.addr = {cmd.addr[fbm_pkg::SECT_LSB +: fbm_pkg::SECT_W],
                               fbm_pkg::PROT_SEL_ADDR[fbm_pkg::SECT_LSB-1:0]};
              n.pins.chip_select_n = 1'b0;
              n.pins.output_enable_n = 1'b0;
              // leaving standby, full select access time
              tmr_load = 1'b1;
              tmr_val = fbm_pkg::TMR_W'(fbm_pkg::CE_CYC);
              n.state = S_RD;
            end
            fbm_pkg::OP_RESET:
            begin
              // remember an embedded operation was cut off
              n.abort_pend = !ready_busy_n;
              n.pins.reset_n = 1'b0;
              tmr_load = 1'b1;
              tmr_val = fbm_pkg::TMR_W'(fbm_pkg::RP_CYC);
              n.state = S_RST_LO;
            end
            fbm_pkg::OP_WRITE, fbm_pkg::OP_AUTOSEL, fbm_pkg::OP_EXIT:
            begin
              n.last = (cmd.op == fbm_pkg::OP_AUTOSEL) ? fbm_pkg::AUTOSEL_LAST : 2'h0;
              {n.pins.addr, n.pins.data_out} = fbm_cyc(cmd.op, 2'h0, cmd.addr, cmd.wdata);
              n.pins.chip_select_n = 1'b0;
              n.pins.data_oe = 1'b1;
              n.state = S_WR_SET;
            end
            default:
            begin
              n.stat.busy = 1'b0;
              n.stat.done = 1'b1;
            end
          endcase
        end
      end
      S_RD:
      begin
        // address held steady, so sleep never corrupts the sample
        if (tmr_done)
        begin
          n.stat.rdata = data_in;
          n.pins.chip_select_n = 1'b1;
          n.pins.output_enable_n = 1'b1;
          n.stat.busy = 1'b0;
          n.stat.done = 1'b1;
          n.state = S_IDLE;
        end
      end
      S_WR_SET:
      begin
        // strobe low with OE held high
        n.pins.write_strobe_n = 1'b0;
        tmr_load = 1'b1;
        tmr_val = fbm_pkg::TMR_W'(fbm_pkg::WP_CYC);
        n.state = S_WR_LO;
      end
      S_WR_LO:
      begin
        if (tmr_done)
        begin
          n.pins.write_strobe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = fbm_pkg::TMR_W'(fbm_pkg::WH_CYC);
          n.state = S_WR_HI;
        end
      end
      S_WR_HI:
      begin
        if (tmr_done)
        begin
          if (r.step == r.last)
          begin
            // deselect is safe even if an embedded op starts
            n.pins.chip_select_n = 1'b1;
            n.pins.data_oe = 1'b0;
            n.stat.busy = 1'b0;
            n.stat.done = 1'b1;
            n.state = S_IDLE;
          end
          else
          begin
            n.step = r.step + 2'h1;
            {n.pins.addr, n.pins.data_out} = fbm_cyc(r.op, n.step, r.pins.addr,
                                                     r.pins.data_out);
            n.state = S_WR_SET;
          end
        end
      end
      S_RST_LO:
      begin
        // held low for the full pulse time
        if (tmr_done)
        begin
          n.pins.reset_n = 1'b1;
          // idle case bounded by the shorter ready time
          tmr_load = 1'b1;
          tmr_val = fbm_pkg::TMR_W'(fbm_pkg::READY_NE_CYC);
          n.state = S_RST_WAIT;
        end
      end
      S_RST_WAIT:
      begin
        // poll busy pin until internal reset ends
        if (tmr_done && ready_busy_n)
        begin
          tmr_load = 1'b1;
          tmr_val = fbm_pkg::TMR_W'(fbm_pkg::RH_CYC);
          n.state = S_RST_REC;
        end
      end
      S_RST_REC:
      begin
        // recovery time before the next read
        if (tmr_done)
        begin
          n.stat.busy = 1'b0;
          n.stat.done = 1'b1;
          n.stat.aborted = r.abort_pend;
          n.abort_pend = 1'b0;
          n.state = S_IDLE;
        end
      end
      default:
      begin
        n.state = S_IDLE;
        n.stat.busy = 1'b0;
      end
    endcase
  end

  // reset leaves the flash deselected and out of reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.state <= S_IDLE;
      r.op <= fbm_pkg::OP_READ;
      r.pins.chip_select_n <= 1'b1;
      r.pins.output_enable_n <= 1'b1;
      r.pins.write_strobe_n <= 1'b1;
      r.pins.reset_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign flash_o = r.pins;
endmodule : fbm_ctrl

// >>> test/fbm_ctrl_assertions.sv
`timescale 1ns/100ps
module fbm_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire fbm_pkg::fbm_pins_s flash_o
);
  logic [7:0] low_cnt_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // width of the flash reset pulse, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_r <= 8'h00;
    else if (flash_o.reset_n)
      low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF)
      low_cnt_r <= low_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_write_levels:
    assert property (!flash_o.write_strobe_n |-> !flash_o.chip_select_n
      && flash_o.output_enable_n && flash_o.data_oe) else $error("bad write levels");
  a_read_levels:
    assert property (!flash_o.output_enable_n |-> !flash_o.chip_select_n
      && flash_o.write_strobe_n && !flash_o.data_oe) else $error("bad read levels");
  a_access_wait:
    assert property ($fell(flash_o.output_enable_n) |-> !flash_o.output_enable_n [*2])
    else $error("read shorter than access time");
  a_reset_width:
    assert property ($rose(flash_o.reset_n) |-> low_cnt_r >= 8'(fbm_pkg::RP_CYC))
    else $error("reset pulse too short");
  a_reset_quiet:
    assert property (!flash_o.reset_n |-> flash_o.chip_select_n && !flash_o.data_oe)
    else $error("bus cycle during reset");
  a_reset_recover:
    assert property ($rose(flash_o.reset_n) |-> flash_o.chip_select_n [*8])
    else $error("access too soon after reset");
  a_idle_release:
    assert property (flash_o.chip_select_n |-> flash_o.output_enable_n
      && flash_o.write_strobe_n && !flash_o.data_oe) else $error("pins not idle");
  a_hv_no_write:
    assert property (flash_o.id_hv_en && !flash_o.chip_select_n |-> flash_o.write_strobe_n)
    else $error("write under high voltage");
  a_apb_answer:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_apb_error:
    assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("apb error flag wrong");

  c_read: cover property ($fell(flash_o.output_enable_n));
  c_write: cover property ($fell(flash_o.write_strobe_n));
  c_reset: cover property ($rose(flash_o.reset_n));
endmodule : fbm_ctrl_chk

bind fbm_ctrl fbm_ctrl_chk fbm_ctrl_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .flash_o(flash_o));

// >>> test/fbm_flash_model.sv
`timescale 1ns/100ps
module fbm_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC6, // arbitrary value
  parameter int READY_EMB_NS = 3000
) (
  input wire fbm_pkg::fbm_pins_s pins,
  input wire logic start_op,
  output logic [7:0] dq,
  output logic dq_drive,
  output logic ready_busy_n
);
  logic [1:0] step_r = 2'h0;
  logic auto_r = 1'b0;
  logic busy_r = 1'b0;
  wire ce_ok;
  wire [5:0] sect;

  // access time must pass after select; a short select never gives data
  assign #(fbm_pkg::T_CE_NS - 1) ce_ok = !pins.chip_select_n;
  // drive only on a qualified read
  assign dq_drive = ce_ok && !pins.chip_select_n && !pins.output_enable_n && pins.reset_n;
  // sector index from the top bits
  assign sect = pins.addr[21:16];
  always_comb
  begin
    if (!(auto_r || pins.id_hv_en))
      dq = pins.addr[7:0] ^ {2'h0, sect};
    else if (pins.addr[1])
      dq = {7'h00, sect[0]};
    else
      dq = pins.addr[0] ? DEV_CODE : MFR_CODE;
  end

  always @(posedge pins.write_strobe_n or negedge pins.reset_n)
  begin
    if (!pins.reset_n)
    begin
      step_r <= 2'h0;
      auto_r <= 1'b0;
    end
    else if (!pins.chip_select_n)
    begin
      if (step_r == 2'h0 && pins.addr == 22'h000555 && pins.data_out == 8'hAA)
        step_r <= 2'h1;
      else if (step_r == 2'h1 && pins.addr == 22'h0002AA && pins.data_out == 8'h55)
        step_r <= 2'h2;
      else
      begin
        auto_r <= step_r == 2'h2 && pins.addr == 22'h000555 && pins.data_out == 8'h90;
        step_r <= 2'h0;
      end
    end
  end

  // a long embedded op ends only through reset
  always @(posedge start_op)
    busy_r = 1'b1;
  always @(negedge pins.reset_n)
    if (busy_r)
      busy_r <= #(READY_EMB_NS) 1'b0;
  assign ready_busy_n = !busy_r;
endmodule : fbm_flash_model

// >>> test/fbm_ctrl_tb_top.sv
`timescale 1ns/100ps
module fbm_ctrl_tb_top;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'hC6; // arbitrary value
  localparam int EMB_NS = 3000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic start_op = 1'b0;
  logic [7:0] dq;
  logic dq_drive;
  logic rb_n;
  logic [7:0] float_r = 8'h3C;
  logic [7:0] data_in;
  fbm_pkg::fbm_pins_s pins;
  logic [31:0] rd;
  logic [31:0] st;
  logic err_seen;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  always #(fbm_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
  // released bus shows a moving pattern so stale data never passes
  always @(posedge pclk) float_r <= ~float_r;
  assign data_in = pins.data_oe ? pins.data_out : (dq_drive ? dq : float_r);

  fbm_ctrl fbm_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_in(data_in), .ready_busy_n(rb_n), .flash_o(pins));
  fbm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .READY_EMB_NS(EMB_NS))
    fbm_flash_model_inst (.pins(pins), .start_op(start_op), .dq(dq), .dq_drive(dq_drive),
    .ready_busy_n(rb_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // one apb transfer; waits on pready, the timeout guards a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_op(input fbm_pkg::fbm_op_e op, input logic [21:0] a,
    input logic [7:0] d, input logic hv);
    apb(1'b1, fbm_pkg::REG_ADDR, {10'h0, a});
    apb(1'b1, fbm_pkg::REG_WDATA, {24'h0, d});
    apb(1'b1, fbm_pkg::REG_CTRL, {27'h0, hv, op, 1'b1});
    do
      apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    while (rd[fbm_pkg::STAT_DONE_BIT] !== 1'b1);
    st = rd;
    apb(1'b1, fbm_pkg::REG_STAT, 32'hC);
  endtask : run_op

  task automatic read_chk(input fbm_pkg::fbm_op_e op, input logic [21:0] a, input logic hv,
    input logic [7:0] exp);
    run_op(op, a, 8'h00, hv);
    apb(1'b0, fbm_pkg::REG_RDATA, 32'h0);
    check("rdata", rd, {24'h0, exp});
  endtask : read_chk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    check("stat_reset", rd, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped_err", {31'h0, err_seen}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, fbm_pkg::REG_ADDR, 32'hFFFFFFFF);
    apb(1'b0, fbm_pkg::REG_ADDR, 32'h0);
    check("addr_back", rd, 32'h003FFFFF);
    // unknown op with go: finishes at once, no bus cycle
    apb(1'b1, fbm_pkg::REG_CTRL, 32'h0000001F);
    apb(1'b0, fbm_pkg::REG_CTRL, 32'h0);
    check("ctrl_back", rd, 32'h0000001E);
    apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    check("bad_op_done", rd, 32'h6);
    apb(1'b1, fbm_pkg::REG_STAT, 32'hC);
    $display("test regs done");
  endtask : t_regs

  task automatic t_array;
    logic [5:0] s;
    for (int i = 0; i < 4; i++)
    begin
      s = 6'(i * 21);
      read_chk(fbm_pkg::OP_READ, {s, 16'h1234}, 1'b0, 8'h34 ^ {2'h0, s});
    end
    $display("test array done");
  endtask : t_array

  task automatic t_autosel;
    run_op(fbm_pkg::OP_AUTOSEL, 22'h0, 8'h00, 1'b0);
    read_chk(fbm_pkg::OP_READ, 22'h0, 1'b0, MFR);
    read_chk(fbm_pkg::OP_READ, 22'h1, 1'b0, DEV);
    read_chk(fbm_pkg::OP_PROTQ, 22'h050000, 1'b0, 8'h01);
    read_chk(fbm_pkg::OP_PROTQ, 22'h040000, 1'b0, 8'h00);
    run_op(fbm_pkg::OP_WRITE, 22'h0, 8'h77, 1'b0);
    read_chk(fbm_pkg::OP_READ, 22'h12, 1'b0, 8'h12);
    run_op(fbm_pkg::OP_AUTOSEL, 22'h0, 8'h00, 1'b0);
    run_op(fbm_pkg::OP_EXIT, 22'h0, 8'h00, 1'b0);
    read_chk(fbm_pkg::OP_READ, 22'h21, 1'b0, 8'h21);
    $display("test autoselect done");
  endtask : t_autosel

  task automatic t_hv;
    read_chk(fbm_pkg::OP_READ, 22'h1, 1'b1, DEV);
    read_chk(fbm_pkg::OP_PROTQ, 22'h3F0000, 1'b1, 8'h01);
    $display("test high voltage done");
  endtask : t_hv

  task automatic t_reset;
    int t0;
    run_op(fbm_pkg::OP_RESET, 22'h0, 8'h00, 1'b0);
    check("idle_reset", st, 32'h6);
    run_op(fbm_pkg::OP_AUTOSEL, 22'h0, 8'h00, 1'b0);
    start_op <= 1'b1;
    @(posedge pclk);
    start_op <= 1'b0;
    run_op(fbm_pkg::OP_READ, 22'h0, 8'h00, 1'b0);
    apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    check("busy_kept", rd & 32'h2, 32'h0);
    t0 = cyc;
    run_op(fbm_pkg::OP_RESET, 22'h0, 8'h00, 1'b0);
    check("emb_reset", st, 32'hE);
    check("emb_wait", {31'h0, (cyc - t0) >= EMB_NS / fbm_pkg::CLK_PERIOD_NS}, 32'h1);
    read_chk(fbm_pkg::OP_READ, 22'h33, 1'b0, 8'h33);
    $display("test reset done");
  endtask : t_reset

  // system reset in the middle of a flash reset pulse
  task automatic t_midrst;
    apb(1'b1, fbm_pkg::REG_CTRL, {27'h0, 1'b0, fbm_pkg::OP_RESET, 1'b1});
    apb(1'b1, fbm_pkg::REG_CTRL, {27'h0, 1'b0, fbm_pkg::OP_READ, 1'b1});
    apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    check("busy_set", rd & 32'h1, 32'h1);
    check("go_refused", {30'h0, pins.reset_n, pins.chip_select_n}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("rst_idle", {27'h0, pins.reset_n, pins.chip_select_n, pins.output_enable_n,
      pins.write_strobe_n, pins.data_oe}, 32'h1E);
    apb(1'b0, fbm_pkg::REG_STAT, 32'h0);
    check("stat_rst", rd, 32'h2);
    read_chk(fbm_pkg::OP_READ, 22'h2A, 1'b0, 8'h2A);
    $display("test mid-run reset done");
  endtask : t_midrst

  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_array;
    t_autosel;
    t_hv;
    t_reset;
    t_midrst;
    report_and_stop;
  end

  // hang guard, far beyond the expected few hundred cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop;
    end
  end
endmodule : fbm_ctrl_tb_top
